/* rtl/drs_pkg.sv */
package drs_pkg;

    // Command codes presented by the command decoder
    typedef enum logic [2:0] {
        DRS_CMD_NOP = 3'b000,
        DRS_CMD_REF = 3'b001,
        DRS_CMD_MRS = 3'b010,
        DRS_CMD_SELF_REFRESH = 3'b011,
        DRS_CMD_TRAIN = 3'b100,
        DRS_CMD_ACCESS = 3'b101
    } drs_cmd_e;

    // Bank geometry
    localparam int DRS_BANKS = 16;
    localparam logic [4:0] DRS_SINGLE_SET = 5'h10;
    localparam logic [4:0] DRS_PAIRED_SET = 5'h08;
    localparam int DRS_RCNT_W = 16;
    localparam logic [15:0] DRS_RCNT_RST = 16'h0000;

    // APB register byte addresses
    localparam logic [7:0] DRS_ADDR_CTRL = 8'h00;
    localparam logic [7:0] DRS_ADDR_STAT = 8'h04;
    localparam logic [7:0] DRS_ADDR_RCNT = 8'h08;
    localparam logic [7:0] DRS_ADDR_TIME = 8'h0c;

    // Control register fields
    localparam int DRS_CTRL_PAIRED = 0;
    localparam int DRS_CTRL_MSB = 1;
    localparam int DRS_CTRL_TREN = 2;
    localparam logic [2:0] DRS_CTRL_RST = 3'h4;

    // Timing, in ns, and cycles at 40 MHz
    localparam int DRS_CLK_NS = 25;
    localparam int DRS_ALL_CYCLE_NS = 200;
    localparam int DRS_BANK_CYCLE_NS = 100;
    localparam int DRS_TRAIN_DLY_NS = 50;
    localparam int DRS_ALL_CYCLE_CYC =
        (DRS_ALL_CYCLE_NS + DRS_CLK_NS - 1) / DRS_CLK_NS;
    localparam int DRS_BANK_CYCLE_CYC =
        (DRS_BANK_CYCLE_NS + DRS_CLK_NS - 1) / DRS_CLK_NS;
    localparam int DRS_TRAIN_DLY_CYC =
        (DRS_TRAIN_DLY_NS + DRS_CLK_NS - 1) / DRS_CLK_NS;

endpackage

/* rtl/drs_bank_mask.sv */
`timescale 1ns/1ps
// Turns a bank address into the set of banks a refresh touches
module drs_bank_mask
    import drs_pkg::*;
(
    input wire logic [3:0] bank,
    input wire logic paired,
    input wire logic msb_pair,
    output logic [15:0] mask
);

    ////////////////////////////////////////////////////////////////////
    // One decode term per bank
    genvar g;
    generate
        for (g = 0; g < DRS_BANKS; g++) begin : g_bank
            localparam logic [3:0] BK = 4'(g);
            always_comb begin
                if (!paired) begin
                    mask[g] = (bank == BK);
                end else if (msb_pair) begin
                    mask[g] = (bank[2:0] == BK[2:0]);
                end else begin
                    mask[g] = (bank[3:1] == BK[3:1]);
                end
            end
        end
    endgenerate

endmodule

/* rtl/drs_refresh_sched.sv */
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
// What this block does, and what it expects of the host
// R01 - Host waits all-bank cycle time after refresh
// R02 - Host precharges every bank before all-bank
// R03 - All-bank rows come from internal counter
// R04 - Host keeps average all-bank refresh interval
// R05 - At most eight all-bank refreshes postponed
// R06 - At most eight pulled in count
// R07 - At most nine all-bank refreshes per interval
// R08 - Training commands allowed after training delay
// R09 - Only temperature field writes during refresh
// R10 - Host sends only no-ops during impedance update
// R11 - Single-bank refresh touches only addressed bank
// R12 - Paired refresh uses pairing select bit
// R13 - Host spaces activate before bank refresh
// R14 - Host spaces bank refreshes by refresh delay
// R15 - Host waits per-bank cycle on same bank
// R16 - Bank precharged; row from internal counter
// R17 - Full set plus cycle time bumps counter
// R18 - Host repeats no bank within a set
// R19 - Reset, all-bank, self-refresh clear bank count
// R20 - Host keeps per-bank average rates
// R21 - Host issues all-bank refresh every millisecond
// R22 - Host finishes set before mode change
// R23 - Bit four splits all-bank from bank refresh
// R24 - Mode bit picks single or paired refresh
// R25 - Bank count wraps at sixteen or eight
module drs_refresh_sched
    import drs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cmd_valid,
    input wire drs_pkg::drs_cmd_e cmd_code,
    input wire logic command_address_bit_four,
    input wire logic [3:0] cmd_bank,
    output logic [15:0] refresh_bank_mask,
    output logic [15:0] refresh_row,
    output logic refresh_busy,
    output logic training_allowed
);
    import drs_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // State
    typedef enum logic [1:0] {
        DRS_IDLE = 2'b00,
        DRS_ALLREF = 2'b01,
        DRS_SETWAIT = 2'b10
    } drs_state_e;

    drs_state_e state_q, state_d;       // Refresh sequencer
    logic [2:0] ctrl_q, ctrl_d;         // Mode, pairing, training bits
    logic [4:0] bank_cnt_q, bank_cnt_d; // Bank refresh commands done in set
    logic [15:0] rcnt_q, rcnt_d;        // Internal refresh counter
    logic [7:0] tmr_q, tmr_d;           // Cycle-time timer
    logic [15:0] mask_q, mask_d;        // Banks under refresh
    logic busy_q, busy_d;
    logic train_q, train_d;
    logic [31:0] rdata_q, rdata_d;
    logic ready_q, ready_d;
    logic err_q, err_d;
    logic [15:0] dec_mask;              // Decoded target banks
    logic [4:0] set_len;                // Refreshes per set

    ////////////////////////////////////////////////////////////////////
    // Bank decode
    drs_bank_mask i_drs_bank_mask (
        .bank(cmd_bank),
        .paired(ctrl_q[DRS_CTRL_PAIRED]),
        .msb_pair(ctrl_q[DRS_CTRL_MSB]),
        .mask(dec_mask)
    );

    // Set length follows refresh mode
    assign set_len = ctrl_q[DRS_CTRL_PAIRED] ? DRS_PAIRED_SET
                                             : DRS_SINGLE_SET; // R24

    ////////////////////////////////////////////////////////////////////
    // Refresh sequencing
    always_comb begin
        state_d = state_q;
        bank_cnt_d = bank_cnt_q;
        rcnt_d = rcnt_q;
        tmr_d = tmr_q;
        mask_d = mask_q;
        busy_d = busy_q;
        train_d = train_q;
        // Timer runs down while nonzero
        if (tmr_q != 8'h00) begin
            tmr_d = tmr_q - 8'h01;
        end
        unique case (state_q)
            DRS_IDLE: begin
                mask_d = 16'h0000;
                busy_d = 1'b0;
            end
            DRS_ALLREF: begin
                // Training window opens after training delay; the flag
                // registers one cycle late, so it is armed one count early
                if (!ctrl_q[DRS_CTRL_TREN] && tmr_q <=
                    8'(DRS_ALL_CYCLE_CYC - DRS_TRAIN_DLY_CYC + 1)) begin
                    train_d = 1'b1; // R08
                end
                if (tmr_q == 8'h00) begin
                    state_d = DRS_IDLE;
                    train_d = 1'b0;
                    busy_d = 1'b0;
                    mask_d = 16'h0000;
                end
            end
            DRS_SETWAIT: begin
                // Counter bumps once the last cycle time has run out
                if (tmr_q == 8'h00) begin
                    rcnt_d = rcnt_q + 16'h0001; // R17
                    state_d = DRS_IDLE;
                    busy_d = 1'b0;
                    mask_d = 16'h0000;
                end
            end
            default: state_d = DRS_IDLE;
        endcase
        // Refresh and self-refresh commands override the running state
        if (cmd_valid && cmd_code == DRS_CMD_REF) begin
            if (command_address_bit_four) begin // R23
                // All-bank: row from counter, bank address ignored
                mask_d = 16'hffff; // R03
                bank_cnt_d = 5'h00; // R19
                rcnt_d = rcnt_q + 16'h0001;
                tmr_d = 8'(DRS_ALL_CYCLE_CYC);
                state_d = DRS_ALLREF;
                busy_d = 1'b1;
                train_d = 1'b0;
            end else begin
                // Bank refresh: only decoded banks, row from counter
                mask_d = dec_mask; // R11 R12 R16
                busy_d = 1'b1;
                tmr_d = 8'(DRS_BANK_CYCLE_CYC);
                if (bank_cnt_q + 5'h01 >= set_len) begin
                    bank_cnt_d = 5'h00; // R25
                    state_d = DRS_SETWAIT; // R17
                end else begin
                    bank_cnt_d = bank_cnt_q + 5'h01;
                    state_d = DRS_IDLE;
                end
            end
        end else if (cmd_valid && cmd_code == DRS_CMD_SELF_REFRESH) begin
            // Self refresh entry drops a partial set uncounted
            bank_cnt_d = 5'h00; // R19
            state_d = DRS_IDLE;
            busy_d = 1'b0;
            train_d = 1'b0;
            mask_d = 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // APB slave, single-cycle answer
    always_comb begin
        ctrl_d = ctrl_q;
        rdata_d = rdata_q;
        ready_d = 1'b0;
        err_d = 1'b0;
        if (psel && !penable) begin
            ready_d = 1'b1;
            rdata_d = 32'h0000_0000;
            unique case (paddr)
                DRS_ADDR_CTRL: rdata_d = {29'h0, ctrl_q};
                DRS_ADDR_STAT: rdata_d = {24'h0, train_q, busy_q,
                                          1'b0, bank_cnt_q};
                DRS_ADDR_RCNT: rdata_d = {16'h0, rcnt_q};
                DRS_ADDR_TIME: rdata_d = {24'h0, tmr_q};
                default: err_d = 1'b1;
            endcase
        end
        // Write lands on the completing access edge
        if (psel && penable && ready_q && pwrite &&
            paddr == DRS_ADDR_CTRL) begin
            ctrl_d = pwdata[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= DRS_IDLE;
            ctrl_q <= DRS_CTRL_RST;
            bank_cnt_q <= 5'h00; // R19
            rcnt_q <= DRS_RCNT_RST;
            tmr_q <= 8'h00;
            mask_q <= 16'h0000;
            busy_q <= 1'b0;
            train_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            ready_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ctrl_q <= ctrl_d;
            bank_cnt_q <= bank_cnt_d;
            rcnt_q <= rcnt_d;
            tmr_q <= tmr_d;
            mask_q <= mask_d;
            busy_q <= busy_d;
            train_q <= train_d;
            rdata_q <= rdata_d;
            ready_q <= ready_d;
            err_q <= err_d;
        end
    end

    // Outputs straight from flip-flops
    assign prdata = rdata_q;
    assign pready = ready_q;
    assign pslverr = err_q;
    assign refresh_bank_mask = mask_q;
    assign refresh_row = rcnt_q;
    assign refresh_busy = busy_q;
    assign training_allowed = train_q;

endmodule

/* verification/drs_refresh_sched_assertions.sv */
`timescale 1ns/1ps
module drs_refresh_sched_assertions
    import drs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic cmd_valid,
    input wire drs_pkg::drs_cmd_e cmd_code,
    input wire logic command_address_bit_four,
    input wire logic [3:0] cmd_bank,
    input wire logic [15:0] refresh_bank_mask,
    input wire logic [15:0] refresh_row,
    input wire logic refresh_busy,
    input wire logic training_allowed
);
    import drs_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Decoded requests
    wire ref_hit = cmd_valid && cmd_code == DRS_CMD_REF;
    wire ab = ref_hit && command_address_bit_four;
    wire pb = ref_hit && !command_address_bit_four;
    wire self_ref = cmd_valid && cmd_code == DRS_CMD_SELF_REFRESH;
    ////////////////////////////////////////////////////////////////////
    property p_ab_mask; ab |=> refresh_bank_mask == 16'hffff; endproperty
    a_ab_mask: assert property (p_ab_mask) else $error("all mask");
    property p_ab_row; ab |=> refresh_row == $past(refresh_row) + 16'h1;
    endproperty
    a_ab_row: assert property (p_ab_row) else $error("all-bank row");
    property p_ab_busy; ab |=> refresh_busy [*7]; endproperty
    a_ab_busy: assert property (p_ab_busy) else $error("busy short");
    property p_pb_bank; pb |=> refresh_bank_mask[$past(cmd_bank)];
    endproperty
    a_pb_bank: assert property (p_pb_bank) else $error("bank miss");
    property p_pb_cnt; pb |=> $countones(refresh_bank_mask) inside {1, 2};
    endproperty
    a_pb_cnt: assert property (p_pb_cnt) else $error("bank count");
    property p_pb_pair; pb |=> $countones(refresh_bank_mask) == 1
        || refresh_bank_mask[$past(cmd_bank) ^ 4'h1]
        || refresh_bank_mask[$past(cmd_bank) ^ 4'h8]; endproperty
    a_pb_pair: assert property (p_pb_pair) else $error("pair");
    property p_self_ref; self_ref |=> $stable(refresh_row); endproperty
    a_self_ref: assert property (p_self_ref) else $error("row moved");
    property p_train; training_allowed |-> refresh_busy; endproperty
    a_train: assert property (p_train) else $error("train idle");
    property p_rdy; psel && !penable |=> pready ##1 !pready; endproperty
    a_rdy: assert property (p_rdy) else $error("pready timing");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("pslverr alone");
    c_ab: cover property (ab);
    c_pb: cover property (pb);
    c_err: cover property (pslverr);
    c_train: cover property (training_allowed);
endmodule
bind drs_refresh_sched drs_refresh_sched_assertions i_chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .command_address_bit_four(command_address_bit_four),
    .cmd_bank(cmd_bank), .refresh_bank_mask(refresh_bank_mask),
    .refresh_row(refresh_row), .refresh_busy(refresh_busy),
    .training_allowed(training_allowed));

/* verification/drs_host_model.sv */
`timescale 1ns/1ps
// Memory controller issuing refresh commands
module drs_host_model
    import drs_pkg::*;
(
    input wire logic pclk,
    input wire logic [15:0] refresh_bank_mask,
    input wire logic training_allowed,
    output logic cmd_valid,
    output drs_pkg::drs_cmd_e cmd_code,
    output logic command_address_bit_four,
    output logic [3:0] cmd_bank,
    output logic [15:0] seen_mask,
    output logic seen_train
);
    import drs_pkg::*;
    initial begin
        cmd_valid = 1'b0;
        cmd_code = DRS_CMD_NOP;
        command_address_bit_four = 1'b0;
        cmd_bank = 4'h0;
    end
    // One command, then the spacing the host owes the device
    task send(input drs_cmd_e c, input logic all, input logic [3:0] b);
        @(posedge pclk);
        // Refreshes only, no activates, one at a time; the run is far
        // shorter than a refresh interval, so no rate limit is neared
        cmd_valid <= 1'b1;
        cmd_code <= c;
        command_address_bit_four <= all;
        cmd_bank <= b;
        @(posedge pclk);
        cmd_valid <= 1'b0;
        cmd_code <= DRS_CMD_NOP;
        command_address_bit_four <= ~all;
        cmd_bank <= ~b;
        seen_train = 1'b0;
        @(posedge pclk);
        seen_mask = refresh_bank_mask;
        // Banks are kept precharged; gap covers cycle times
        repeat (all ? DRS_ALL_CYCLE_CYC : DRS_BANK_CYCLE_CYC) begin
            @(posedge pclk);
            seen_train = seen_train | (training_allowed === 1'b1);
        end
    endtask
endmodule

/* verification/drs_refresh_sched_bench.sv */
`timescale 1ns/1ps
module drs_refresh_sched_bench;
    import drs_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic cmd_valid, cab4, busy, train, seen_train;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    drs_cmd_e cmd_code;
    logic [3:0] cmd_bank;
    logic [15:0] mask, row, seen_mask, e, exp_row;
    int n_errors, num_checks, m, k;
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    drs_refresh_sched i_drs_refresh_sched (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .command_address_bit_four(cab4), .cmd_bank(cmd_bank),
        .refresh_bank_mask(mask), .refresh_row(row),
        .refresh_busy(busy), .training_allowed(train));
    drs_host_model i_drs_host_model (.pclk(pclk), .refresh_bank_mask(mask),
        .training_allowed(train), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .command_address_bit_four(cab4),
        .cmd_bank(cmd_bank), .seen_mask(seen_mask),
        .seen_train(seen_train));
    ////////////////////////////////////////////////////////////////////
    task give_verdict;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        num_checks++;
        if (g !== x) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, x, g);
        end
    endtask
    // One APB transfer, held until pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            n_errors++;
            give_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wait_idle;
        int i;
        for (i = 0; i < 50; i++) begin
            @(posedge pclk);
            if (busy === 1'b0) break;
        end
        if (i == 50) begin
            n_errors++;
            give_verdict();
        end
        apb(0, DRS_ADDR_RCNT, 0);
        chk("row", {16'h0, exp_row}, rd);
        chk("row pin", {16'h0, exp_row}, {16'h0, row});
        apb(0, DRS_ADDR_STAT, 0);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        n_errors = 0;
        num_checks = 0;
        exp_row = DRS_RCNT_RST;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, DRS_ADDR_CTRL, 0);
        chk("ctrl reset", {29'h0, DRS_CTRL_RST}, rd);
        apb(1, 8'h10, 32'hffffffff);
        chk("unmapped err", 32'h1, {31'h0, err});
        apb(0, 8'h10, 0);
        chk("unmapped data", 32'h0, rd);
        apb(0, DRS_ADDR_TIME, 0);
        chk("timer idle", 32'h0, rd);
        $display("test registers done");
        // All-bank refresh with training enabled, then disabled
        for (m = 0; m < 2; m++) begin
            apb(1, DRS_ADDR_CTRL, m << DRS_CTRL_TREN);
            i_drs_host_model.send(DRS_CMD_REF, 1'b1, 4'h5);
            exp_row++;
            chk("all mask", 32'hffff, {16'h0, seen_mask});
            chk("training", m == 0, {31'h0, seen_train});
            wait_idle();
            chk("status idle", 32'h0, rd);
        end
        $display("test all-bank done");
        // Full sets: single reversed, paired low bit, paired high bit
        for (m = 0; m < 3; m++) begin
            apb(1, DRS_ADDR_CTRL, m == 0 ? 0 : (m == 1 ? 1 : 3));
            for (k = 0; k < (m == 0 ? 16 : 8); k++) begin
                e = m == 0 ? 16'h1 << (15 - k) :
                    (m == 1 ? 16'h3 << (2 * k) : 16'h0101 << k);
                i_drs_host_model.send(DRS_CMD_REF, 1'b0,
                    m == 0 ? 15 - k : (m == 1 ? 2 * k : k));
                chk("bank mask", {16'h0, e}, {16'h0, seen_mask});
            end
            exp_row++;
            wait_idle();
            chk("count wrap", 32'h0, rd & 32'h1f);
        end
        $display("test bank sets done");
        // Partial set cut short by all-bank, then by self-refresh entry
        apb(1, DRS_ADDR_CTRL, 0);
        for (m = 0; m < 2; m++) begin
            i_drs_host_model.send(DRS_CMD_REF, 1'b0, 4'h3);
            i_drs_host_model.send(DRS_CMD_REF, 1'b0, 4'h9);
            wait_idle();
            chk("partial count", 32'h2, rd & 32'h1f);
            i_drs_host_model.send(m ? DRS_CMD_SELF_REFRESH : DRS_CMD_REF,
                1'b1, 4'h0);
            exp_row = exp_row + (m == 0);
            wait_idle();
            chk("count cleared", 32'h0, rd & 32'h1f);
        end
        $display("test bank count sync done");
        give_verdict();
    end
endmodule
